// >>> erf_rx_filter.sv
// Receive packet acceptance filter with its register file.
`include "erf_cfg.svh"
`default_nettype none

module erf_rx_filter (
  // Clock and reset.
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  // Register port.
  input  wire erf_pkg::erf_addr_type i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output var  logic [31:0]          o_rdata,
  // Received byte stream.
  input  wire logic                 i_rx_valid,
  input  wire erf_pkg::erf_byte_type i_rx_data,
  input  wire logic                 i_rx_sof,
  input  wire logic                 i_rx_eof,
  input  wire logic                 i_rx_crc_ok,
  // Result.
  output var  logic                 o_frame_done,
  output var  logic                 o_frame_accept,
  output var  logic                 o_rx_enable
);
  import erf_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Registers that software owns.

  logic [31:0]   hash_low_reg;
  logic [31:0]   hash_upper_reg;
  logic [31:0]   mask_low_reg;
  logic [31:0]   mask_high_reg;
  logic [15:0]   checksum_reg;
  logic [15:0]   offset_reg;
  logic [31:0]   cfg_reg;
  logic          rx_enable_reg;
  logic [31:0]   station_low_reg;
  logic [15:0]   station_high_reg;
  logic [31:0]   rdata_reg;
  // Filter state.
  erf_state_type state_reg;
  erf_state_type state_next;
  logic [15:0]   count_reg;
  logic [15:0]   count_next;
  logic [47:0]   dest_reg;
  logic [47:0]   dest_next;
  logic [31:0]   dcrc_reg;
  logic [31:0]   dcrc_next;
  logic [15:0]   csum_reg;
  logic [15:0]   csum_next;
  logic [2:0]    sync_reg;
  logic [2:0]    sync_next;
  logic [6:0]    magic_cnt_reg;
  logic [6:0]    magic_cnt_next;
  logic [2:0]    magic_sel_reg;
  logic [2:0]    magic_sel_next;
  logic          magic_reg;
  logic          magic_next;
  logic          done_reg;
  logic          accept_reg;
  logic [3:0]    hits_reg;
  logic [15:0]   accepted_reg;
  // Views of the register contents.
  logic [63:0]   hash_table_bits;
  logic [63:0]   pattern_mask_bits;
  logic [47:0]   station_addr;
  logic [3:0]    pattern_mode_select;
  logic          invert_checksum_match;
  assign hash_table_bits     = {hash_upper_reg, hash_low_reg};
  assign pattern_mask_bits   = {mask_high_reg, mask_low_reg};
  assign station_addr        = {station_high_reg, station_low_reg};
  assign pattern_mode_select = cfg_reg[`ERF_MODE_HI:`ERF_MODE_LO];
  assign invert_checksum_match = cfg_reg[`ERF_BIT_INVERT];
  ////////////////////////////////////////////////////////////////////////////////
  // One byte step of the reflected Ethernet CRC.

  function automatic logic [31:0] erf_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      r = (r[0] ^ d[k]) ? ((r >> 1) ^ `ERF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Register writes; software is trusted to write only while receive is quiet.

  // Hash table words.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hash_low_reg   <= `ERF_RST_WORD;
      hash_upper_reg <= `ERF_RST_WORD;
    end else if (i_wr) begin
      if (i_addr == `ERF_ADDR_HASH_LOW) hash_low_reg <= i_wdata;
      if (i_addr == `ERF_ADDR_HASH_UPPER) hash_upper_reg <= i_wdata;
    end
  end

  // Pattern mask, checksum and offset.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_low_reg  <= `ERF_RST_WORD;
      mask_high_reg <= `ERF_RST_WORD;
      checksum_reg  <= `ERF_RST_HALF;
      offset_reg    <= `ERF_RST_HALF;
    end else if (i_wr) begin
      if (i_addr == `ERF_ADDR_MASK_LOW) mask_low_reg <= i_wdata;
      if (i_addr == `ERF_ADDR_MASK_HIGH) mask_high_reg <= i_wdata;
      if (i_addr == `ERF_ADDR_CHECKSUM) checksum_reg <= i_wdata[15:0];
      if (i_addr == `ERF_ADDR_OFFSET) offset_reg <= i_wdata[15:0];
    end
  end

  // Filter configuration, receive enable and station address.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg          <= `ERF_RST_WORD;
      rx_enable_reg    <= 1'b0;
      station_low_reg  <= `ERF_RST_WORD;
      station_high_reg <= `ERF_RST_HALF;
    end else if (i_wr) begin
      if (i_addr == `ERF_ADDR_FILTER_CFG) cfg_reg <= i_wdata & `ERF_CFG_WRITE_MASK;
      if (i_addr == `ERF_ADDR_CONTROL) rx_enable_reg <= i_wdata[`ERF_BIT_RX_ENABLE];
      if (i_addr == `ERF_ADDR_STATION_LOW) station_low_reg <= i_wdata;
      if (i_addr == `ERF_ADDR_STATION_HIGH) station_high_reg <= i_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads; data stand in the cycle after the strobe, unmapped reads zero.

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= `ERF_RST_WORD;
    end else if (i_rd) begin
      unique case (i_addr)
        `ERF_ADDR_HASH_LOW:     rdata_reg <= hash_low_reg;
        `ERF_ADDR_HASH_UPPER:   rdata_reg <= hash_upper_reg;
        `ERF_ADDR_MASK_LOW:     rdata_reg <= mask_low_reg;
        `ERF_ADDR_MASK_HIGH:    rdata_reg <= mask_high_reg;
        `ERF_ADDR_CHECKSUM:     rdata_reg <= {`ERF_RST_HALF, checksum_reg};
        `ERF_ADDR_OFFSET:       rdata_reg <= {`ERF_RST_HALF, offset_reg};
        `ERF_ADDR_FILTER_CFG:   rdata_reg <= cfg_reg;
        `ERF_ADDR_CONTROL:      rdata_reg <= {31'h0000_0000, rx_enable_reg};
        `ERF_ADDR_STATION_LOW:  rdata_reg <= station_low_reg;
        `ERF_ADDR_STATION_HIGH: rdata_reg <= {`ERF_RST_HALF, station_high_reg};
        `ERF_ADDR_STATUS:       rdata_reg <= {accepted_reg, 12'h000, hits_reg};
        default:                rdata_reg <= `ERF_RST_WORD;
      endcase
    end else begin
      rdata_reg <= `ERF_RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte walk through a frame.

  logic          take;
  logic [15:0]   cur_idx;
  logic [15:0]   rel_idx;
  logic          in_window;
  logic [15:0]   add_word;
  logic [16:0]   sum_wide;
  logic [15:0]   csum_base;
  logic [7:0]    station_byte;
  // A frame is only taken if receive was enabled when its first byte came.
  assign take    = i_rx_valid & (i_rx_sof ? rx_enable_reg : (state_reg == ERF_FRAME));
  assign cur_idx = i_rx_sof ? 16'h0000 : count_reg;

  // Bytes of the pattern window are paired big-endian for the 16-bit sum.
  assign rel_idx   = cur_idx - offset_reg;
  assign in_window = (cur_idx >= offset_reg) && (rel_idx < `ERF_PM_WINDOW);
  assign add_word  = rel_idx[0] ? {8'h00, i_rx_data} : {i_rx_data, 8'h00};
  assign csum_base = i_rx_sof ? 16'h0000 : csum_reg;
  assign sum_wide  = {1'b0, csum_base} + {1'b0, add_word};
  assign station_byte = station_addr[{magic_sel_reg, 3'b000} +: 8];

  // Next state of the frame walk, the address capture and the checksum.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    dest_next  = dest_reg;
    dcrc_next  = dcrc_reg;
    csum_next  = csum_reg;
    if (take) begin
      state_next = i_rx_eof ? ERF_IDLE : ERF_FRAME;
      count_next = (cur_idx == 16'hffff) ? cur_idx : cur_idx + 16'h0001;
      csum_next  = csum_base;
      if (i_rx_sof) begin
        dcrc_next = `ERF_CRC_INIT;
      end
      if (cur_idx < `ERF_DEST_BYTES) begin
        dest_next[{cur_idx[2:0], 3'b000} +: 8] = i_rx_data;
        dcrc_next = erf_crc_byte(i_rx_sof ? `ERF_CRC_INIT : dcrc_reg, i_rx_data);
      end
      if (in_window && pattern_mask_bits[rel_idx[5:0]]) begin
        csum_next = sum_wide[15:0] + {15'h0000, sum_wide[16]};
      end
    end
  end

  // Magic frame search: six sync bytes then sixteen copies of the station address.
  always_comb begin
    sync_next      = sync_reg;
    magic_cnt_next = magic_cnt_reg;
    magic_sel_next = magic_sel_reg;
    magic_next     = magic_reg;
    if (take) begin
      if (i_rx_sof) begin
        sync_next      = (i_rx_data == `ERF_SYNC_BYTE) ? 3'h1 : 3'h0;
        magic_cnt_next = 7'h00;
        magic_sel_next = 3'h0;
        magic_next     = 1'b0;
      end else if (!magic_reg) begin
        if (sync_reg == `ERF_SYNC_COUNT) begin
          if (i_rx_data == station_byte) begin
            magic_cnt_next = magic_cnt_reg + 7'h01;
            magic_sel_next = (magic_sel_reg == `ERF_ADDR_LAST_BYTE) ? 3'h0
                                                                    : magic_sel_reg + 3'h1;
            magic_next     = (magic_cnt_reg == `ERF_MAGIC_LAST);
          end else begin
            sync_next      = (i_rx_data == `ERF_SYNC_BYTE) ? `ERF_SYNC_COUNT : 3'h0;
            magic_cnt_next = 7'h00;
            magic_sel_next = 3'h0;
          end
        end else begin
          sync_next = (i_rx_data == `ERF_SYNC_BYTE) ? sync_reg + 3'h1 : 3'h0;
        end
      end
    end
  end

  // Frame walk registers.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= ERF_IDLE;
      count_reg     <= `ERF_RST_HALF;
      dest_reg      <= 48'h0000_0000_0000;
      dcrc_reg      <= `ERF_CRC_INIT;
      csum_reg      <= `ERF_RST_HALF;
      sync_reg      <= 3'h0;
      magic_cnt_reg <= 7'h00;
      magic_sel_reg <= 3'h0;
      magic_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      count_reg     <= count_next;
      dest_reg      <= dest_next;
      dcrc_reg      <= dcrc_next;
      csum_reg      <= csum_next;
      sync_reg      <= sync_next;
      magic_cnt_reg <= magic_cnt_next;
      magic_sel_reg <= magic_sel_next;
      magic_reg     <= magic_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decision on the last byte, using the values that include that byte.

  logic [31:0]   dcrc_final;
  logic          hash_hit;
  logic          is_bcast;
  logic          is_mcast;
  logic          is_ucast;
  logic          is_me;
  logic          csum_term;
  logic          pattern_hit;
  logic          is_short;
  logic          require_ok;
  logic          any_accept;
  logic          decision;
  assign dcrc_final = ~dcrc_next;
  assign hash_hit   = hash_table_bits[dcrc_final[31:26]];
  assign is_bcast   = (dest_next == `ERF_BCAST_ADDR);
  assign is_mcast   = dest_next[0] & ~is_bcast;
  assign is_ucast   = ~dest_next[0];
  assign is_me      = (dest_next == station_addr);
  assign is_short   = (count_next < `ERF_SHORT_BYTES);
  assign csum_term  = invert_checksum_match ^ (csum_next == checksum_reg);

  // Pattern mode decode; codes above nine behave as disabled.
  always_comb begin
    unique case (pattern_mode_select)
      `ERF_MODE_OFF:                 pattern_hit = 1'b0;
      `ERF_MODE_CSUM:                pattern_hit = csum_term;
      `ERF_MODE_STA_A, `ERF_MODE_STA_B: pattern_hit = csum_term & is_me;
      `ERF_MODE_UNI_A, `ERF_MODE_UNI_B: pattern_hit = csum_term & is_ucast;
      `ERF_MODE_BC_A, `ERF_MODE_BC_B:   pattern_hit = csum_term & is_bcast;
      `ERF_MODE_HASH:                pattern_hit = csum_term & hash_hit;
      `ERF_MODE_MAGIC:               pattern_hit = csum_term & magic_next;
      default:                       pattern_hit = 1'b0;
    endcase
  end

  // Qualifying filters must all pass.
  assign require_ok =
      (~cfg_reg[`ERF_BIT_BAD_CRC] | ~i_rx_crc_ok) &
      (~cfg_reg[`ERF_BIT_GOOD_CRC] | i_rx_crc_ok) &
      (~cfg_reg[`ERF_BIT_SHORT_COLL] |
       (is_short & (~cfg_reg[`ERF_BIT_GOOD_CRC] | i_rx_crc_ok))) &
      (~cfg_reg[`ERF_BIT_SHORT_REJ] | ~is_short);

  // Any one accepting filter admits the frame.
  assign any_accept =
      (cfg_reg[`ERF_BIT_UNICAST] & is_ucast & is_me) |
      (cfg_reg[`ERF_BIT_OTHER_UNI] & is_ucast & ~is_me) |
      (cfg_reg[`ERF_BIT_MULTICAST] & is_mcast) |
      (cfg_reg[`ERF_BIT_BROADCAST] & is_bcast) |
      (cfg_reg[`ERF_BIT_HASH_EN] & hash_hit) |
      (cfg_reg[`ERF_BIT_MAGIC_EN] & magic_next) |
      pattern_hit;

  assign decision = rx_enable_reg & require_ok & any_accept;

  // Result outputs and status; the accept level holds until the next frame ends.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_reg     <= 1'b0;
      accept_reg   <= 1'b0;
      hits_reg     <= 4'h0;
      accepted_reg <= `ERF_RST_HALF;
    end else begin
      done_reg <= take & i_rx_eof;
      if (take && i_rx_eof) begin
        accept_reg <= decision;
        hits_reg   <= {pattern_hit, magic_next, hash_hit, decision};
        if (decision) begin
          accepted_reg <= accepted_reg + 16'h0001;
        end
      end
    end
  end

  // Every output leaves straight from a flip-flop.
  assign o_rdata        = rdata_reg;
  assign o_frame_done   = done_reg;
  assign o_frame_accept = accept_reg;
  assign o_rx_enable    = rx_enable_reg;

endmodule

`default_nettype wire

// >>> erf_cfg.svh
// Register map, field positions, reset values and fixed counts of the receive packet filter.
`ifndef ERF_CFG_SVH
`define ERF_CFG_SVH

// Register byte addresses.
`define ERF_ADDR_HASH_LOW     8'h00
`define ERF_ADDR_HASH_UPPER   8'h04
`define ERF_ADDR_MASK_LOW     8'h08
`define ERF_ADDR_MASK_HIGH    8'h0c
`define ERF_ADDR_CHECKSUM     8'h10
`define ERF_ADDR_OFFSET       8'h14
`define ERF_ADDR_FILTER_CFG   8'h18
`define ERF_ADDR_CONTROL      8'h1c
`define ERF_ADDR_STATION_LOW  8'h20
`define ERF_ADDR_STATION_HIGH 8'h24
`define ERF_ADDR_STATUS       8'h28

// Reset values.
`define ERF_RST_WORD          32'h0000_0000
`define ERF_RST_HALF          16'h0000

// Filter configuration and control register fields.
`define ERF_CFG_WRITE_MASK    32'h0000_dfff
`define ERF_BIT_HASH_EN       15
`define ERF_BIT_MAGIC_EN      14
`define ERF_BIT_INVERT        12
`define ERF_MODE_HI           11
`define ERF_MODE_LO           8
`define ERF_BIT_BAD_CRC       7
`define ERF_BIT_GOOD_CRC      6
`define ERF_BIT_SHORT_COLL    5
`define ERF_BIT_SHORT_REJ     4
`define ERF_BIT_UNICAST       3
`define ERF_BIT_OTHER_UNI     2
`define ERF_BIT_MULTICAST     1
`define ERF_BIT_BROADCAST     0
`define ERF_BIT_RX_ENABLE     0

// Pattern modes.
`define ERF_MODE_OFF          4'h0
`define ERF_MODE_CSUM         4'h1
`define ERF_MODE_STA_A        4'h2
`define ERF_MODE_STA_B        4'h3
`define ERF_MODE_UNI_A        4'h4
`define ERF_MODE_UNI_B        4'h5
`define ERF_MODE_BC_A         4'h6
`define ERF_MODE_BC_B         4'h7
`define ERF_MODE_HASH         4'h8
`define ERF_MODE_MAGIC        4'h9

// Frame constants.
`define ERF_SHORT_BYTES       16'h0040
`define ERF_DEST_BYTES        16'h0006
`define ERF_PM_WINDOW         16'h0040
`define ERF_CRC_INIT          32'hffff_ffff
`define ERF_CRC_POLY          32'hedb8_8320
`define ERF_BCAST_ADDR        48'hffff_ffff_ffff
`define ERF_SYNC_BYTE         8'hff
`define ERF_SYNC_COUNT        3'h6
`define ERF_ADDR_LAST_BYTE    3'h5
`define ERF_MAGIC_LAST        7'h5f

`endif

// >>> erf_pkg.sv
// Types shared by the receive packet filter.
`default_nettype none
package erf_pkg;
  typedef logic [7:0] erf_byte_type;
  typedef logic [7:0] erf_addr_type;
  typedef enum logic {ERF_IDLE, ERF_FRAME} erf_state_type;
endpackage
`default_nettype wire

// >>> erf_rx_filter_properties.sv
// Port checker of the receive packet filter, bound to its top module.
`include "erf_cfg.svh"
`default_nettype none
module erf_rx_filter_chk (
  // Clock and reset.
  input wire logic                  i_clock,
  input wire logic                  i_rst_n,
  // Register port.
  input wire erf_pkg::erf_addr_type i_addr,
  input wire logic [31:0]           i_wdata,
  input wire logic                  i_wr,
  input wire logic                  i_rd,
  input wire logic [31:0]           o_rdata,
  // Frame stream and result.
  input wire logic                  i_rx_valid,
  input wire erf_pkg::erf_byte_type i_rx_data,
  input wire logic                  i_rx_sof,
  input wire logic                  i_rx_eof,
  input wire logic                  i_rx_crc_ok,
  input wire logic                  o_frame_done,
  input wire logic                  o_frame_accept,
  input wire logic                  o_rx_enable
);
  import erf_pkg::*;
  logic [15:0] cfg_reg;
  logic [15:0] len_reg;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////////////////
  // Shadow of the filter configuration as software wrote it.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= 16'h0000;
    end else if (i_wr && i_addr == `ERF_ADDR_FILTER_CFG) begin
      cfg_reg <= i_wdata[15:0];
    end
  end
  // Byte count of the current frame, so it holds the full length in the done cycle.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      len_reg <= 16'h0000;
    end else if (i_rx_valid && i_rx_sof) begin
      len_reg <= 16'h0001;
    end else if (i_rx_valid) begin
      len_reg <= len_reg + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  // Register port and frame result timing.
  property p_rdata_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present outside its answer cycle");
  property p_csum_upper;
    $past(i_rd && i_addr == `ERF_ADDR_CHECKSUM) |-> o_rdata[31:16] == 16'h0000; endproperty
  a_csum_upper: assert property (p_csum_upper)
    else $error("checksum upper half not zero");
  property p_offset_upper;
    $past(i_rd && i_addr == `ERF_ADDR_OFFSET) |-> o_rdata[31:16] == 16'h0000; endproperty
  a_offset_upper: assert property (p_offset_upper)
    else $error("offset upper half not zero");
  property p_done_eof; o_frame_done |-> $past(i_rx_valid && i_rx_eof); endproperty
  a_done_eof: assert property (p_done_eof)
    else $error("frame done without a last byte");
  property p_accept_hold; !o_frame_done |-> $stable(o_frame_accept); endproperty
  a_accept_hold: assert property (p_accept_hold)
    else $error("accept changed between frames");
  property p_accept_en; o_frame_done && o_frame_accept |-> o_rx_enable; endproperty
  a_accept_en: assert property (p_accept_en)
    else $error("frame accepted with receive off");
  // Qualifier filters checked against the shadowed configuration.
  property p_good_crc;
    o_frame_done && o_frame_accept && cfg_reg[6] |-> $past(i_rx_crc_ok); endproperty
  a_good_crc: assert property (p_good_crc)
    else $error("bad crc frame accepted");
  property p_bad_crc;
    o_frame_done && o_frame_accept && cfg_reg[7] |-> !$past(i_rx_crc_ok); endproperty
  a_bad_crc: assert property (p_bad_crc)
    else $error("good crc frame collected");
  property p_short_coll;
    o_frame_done && o_frame_accept && cfg_reg[5] |-> len_reg < 16'h0040; endproperty
  a_short_coll: assert property (p_short_coll)
    else $error("long frame collected as short");
  property p_short_rej;
    o_frame_done && o_frame_accept && cfg_reg[4] |-> len_reg >= 16'h0040; endproperty
  a_short_rej: assert property (p_short_rej)
    else $error("short frame accepted");
  // Main scenarios.
  c_accept: cover property (o_frame_done && o_frame_accept);
  c_reject: cover property (o_frame_done && !o_frame_accept);
  c_read: cover property ($past(i_rd));
endmodule
bind erf_rx_filter erf_rx_filter_chk erf_rx_filter_chk_i (
  .i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rx_valid, .i_rx_data,
  .i_rx_sof, .i_rx_eof, .i_rx_crc_ok, .o_frame_done, .o_frame_accept, .o_rx_enable
);
`default_nettype wire

// >>> erf_mac_src.sv
// Receive datapath model that streams one frame per start pulse.
`default_nettype none
module erf_mac_src (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Frame request: a one-cycle start pulse, with the settings held for the whole frame.
  input  wire logic        i_start,
  input  wire logic        i_slow,
  input  wire logic        i_crc_ok,
  input  wire logic        i_magic,
  input  wire logic [47:0] i_dest,
  input  wire logic [15:0] i_len,
  // Byte stream toward the filter.
  output var  logic        o_valid,
  output var  logic        o_sof,
  output var  logic        o_eof,
  output var  logic        o_crc_ok,
  output var  logic [7:0]  o_data
);
  logic [15:0] idx_reg;
  logic        busy_reg;
  // Destination first, then a sync run with address copies if magic is set, then a plain count.
  function automatic logic [7:0] byte_at(input logic [15:0] k);
    if (k < 16'h0006) return i_dest[8*k +: 8];
    if (i_magic && k < 16'h000c) return 8'hff;
    if (i_magic && k < 16'h006c) return i_dest[8*((k - 16'h000c) % 6) +: 8];
    return k[7:0];
  endfunction
  // Slow mode leaves a gap after each byte; idle data toggles so stale bytes never match.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {busy_reg, o_valid, o_sof, o_eof, o_crc_ok} <= 5'h00;
      idx_reg <= 16'h0000;
      o_data <= 8'h00;
    end else if (i_start) begin
      busy_reg <= 1'b1;
      idx_reg <= 16'h0000;
    end else if (busy_reg && !(o_valid && (o_eof || i_slow))) begin
      o_valid <= 1'b1;
      o_sof <= idx_reg == 16'h0000;
      o_eof <= idx_reg == i_len - 16'h0001;
      o_crc_ok <= i_crc_ok && idx_reg == i_len - 16'h0001;
      o_data <= byte_at(idx_reg);
      idx_reg <= idx_reg + 16'h0001;
    end else begin
      busy_reg <= busy_reg && !(o_valid && o_eof);
      {o_valid, o_sof, o_eof, o_crc_ok} <= 4'h0;
      o_data <= ~o_data;
    end
  end
endmodule
`default_nettype wire

// >>> erf_tb.sv
// Self-checking bench of the receive packet filter.
`include "erf_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import erf_pkg::*;
  logic                  i_clock = 1'b0;
  logic                  i_rst_n = 1'b1;
  erf_pkg::erf_addr_type i_addr = 8'h00;
  logic [31:0]           i_wdata = 32'h0000_0000;
  logic                  i_wr = 1'b0;
  logic                  i_rd = 1'b0;
  logic [31:0]           o_rdata;
  logic                  i_rx_valid, i_rx_sof, i_rx_eof, i_rx_crc_ok;
  erf_pkg::erf_byte_type i_rx_data;
  logic                  o_frame_done, o_frame_accept, o_rx_enable;
  logic                  s_start = 1'b0, s_slow = 1'b0, s_crc = 1'b0, s_magic = 1'b0;
  logic [47:0]           s_dest = 48'h0000_0000_0000;
  logic [15:0]           s_len = 16'h0000;
  int                    failures = 0, compares = 0, dones = 0;
  // Station, other unicast, multicast and broadcast destinations.
  logic [47:0] dests [4] = '{48'h6655_4433_0102, 48'h6655_4433_0104,
                             48'h6655_4433_0103, 48'hffff_ffff_ffff};
  logic [7:0]  regs [6] = '{`ERF_ADDR_HASH_UPPER, `ERF_ADDR_MASK_LOW, `ERF_ADDR_MASK_HIGH,
                            `ERF_ADDR_CHECKSUM, `ERF_ADDR_OFFSET, `ERF_ADDR_FILTER_CFG};
  logic [31:0] wmask [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
                             32'h0000_ffff, 32'h0000_ffff, 32'h0000_dfff};
  erf_rx_filter erf_rx_filter_i (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx_valid, .i_rx_data, .i_rx_sof, .i_rx_eof, .i_rx_crc_ok, .o_frame_done,
    .o_frame_accept, .o_rx_enable);
  erf_mac_src erf_mac_src_i (.i_clock, .i_rst_n, .i_start(s_start), .i_slow(s_slow),
    .i_crc_ok(s_crc), .i_magic(s_magic), .i_dest(s_dest), .i_len(s_len), .o_valid(i_rx_valid),
    .o_sof(i_rx_sof), .o_eof(i_rx_eof), .o_crc_ok(i_rx_crc_ok), .o_data(i_rx_data));
  ////////////////////////////////////////////////////////////////////////////////////////
  // Clock and count of finished frames.
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (o_frame_done === 1'b1) dones <= dones + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    check(o_rdata, exp);
  endtask
  // Hash table is only touched with receive off.
  task automatic hash(input logic [31:0] v);
    wr(`ERF_ADDR_CONTROL, 32'h0000_0000);
    wr(`ERF_ADDR_HASH_LOW, v);
    wr(`ERF_ADDR_HASH_UPPER, v);
  endtask
  // Configure with receive off, then send one frame and judge the result.
  task automatic frm(input logic [15:0] cfg, input int ds, input logic [15:0] len,
                     input logic crc, input logic mag, input logic exp, input logic en);
    int n;
    wr(`ERF_ADDR_CONTROL, 32'h0000_0000);
    wr(`ERF_ADDR_FILTER_CFG, {16'h0000, cfg});
    wr(`ERF_ADDR_CONTROL, {31'h0, en});
    @(posedge i_clock);
    n = dones;
    s_dest <= dests[ds];
    s_len <= len;
    s_crc <= crc;
    s_magic <= mag;
    s_slow <= ~s_slow;
    s_start <= 1'b1;
    @(posedge i_clock);
    s_start <= 1'b0;
    for (int t = 0; t < 400 && dones == n; t++) @(negedge i_clock);
    check({31'h0, dones != n}, {31'h0, en});
    if (en) check({31'h0, o_frame_accept}, {31'h0, exp});
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run of some five thousand cycles.
  initial begin
    #800us;
    failures++;
    test_done();
  end
  // Main sequence.
  initial begin
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) rd(regs[k], 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      wr(regs[k], 32'hffff_ffff);
      rd(regs[k], wmask[k]);
    end
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0000_0000);
    wr(`ERF_ADDR_MASK_HIGH, 32'h8000_0000);
    rd(`ERF_ADDR_MASK_HIGH, 32'h8000_0000);
    wr(`ERF_ADDR_MASK_HIGH, 32'h0000_0000);
    wr(`ERF_ADDR_STATION_LOW, 32'h4433_0102);
    wr(`ERF_ADDR_STATION_HIGH, 32'h0000_6655);
    wr(`ERF_ADDR_MASK_LOW, 32'h0000_0003);
    wr(`ERF_ADDR_CHECKSUM, 32'h0000_0201);
    wr(`ERF_ADDR_OFFSET, 32'h0000_0000);
    hash(32'h0000_0000);
    frm(16'h0008, 0, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0008, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0004, 1, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0004, 0, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0002, 2, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0002, 3, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0001, 3, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0001, 2, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0041, 3, 8'h40, 1'b0, 1'b0, 1'b0, 1'b1);
    frm(16'h0081, 3, 8'h40, 1'b0, 1'b0, 1'b1, 1'b1);
    frm(16'h0081, 3, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0021, 3, 8'h3f, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0021, 3, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0061, 3, 8'h3f, 1'b0, 1'b0, 1'b0, 1'b1);
    frm(16'h0011, 3, 8'h3f, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0011, 3, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h4000, 0, 8'h78, 1'b1, 1'b1, 1'b1, 1'b1);
    frm(16'h4000, 0, 8'h78, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0000, 0, 8'h78, 1'b1, 1'b1, 1'b0, 1'b1);
    frm(16'h0100, 0, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0100, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h1100, 0, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h1100, 1, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0000, 0, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h1000, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h1a00, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0200, 0, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h1300, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0400, 0, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h1500, 3, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h1500, 1, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h1600, 3, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h1700, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0800, 0, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h8000, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    hash(32'hffff_ffff);
    frm(16'h0800, 0, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h8000, 1, 8'h40, 1'b1, 1'b0, 1'b1, 1'b1);
    frm(16'h0000, 1, 8'h40, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0900, 0, 8'h78, 1'b1, 1'b1, 1'b1, 1'b1);
    frm(16'h0900, 0, 8'h78, 1'b1, 1'b0, 1'b0, 1'b1);
    frm(16'h0001, 3, 8'h40, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(`ERF_ADDR_STATUS, 32'h0011_0002);
    test_done();
  end
endmodule
`default_nettype wire
